/* File: verilog/dar_regbank.sv */
`timescale 1ns/1ps
module dar_regbank (
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        sclk_pin,
   input  wire logic        din_pin,
   input  wire logic        cs_n_pin,
   output logic             dout,
   output logic             dout_oe,
   input  wire logic        primary_result_ready,
   input  wire logic        secondary_result_ready,
   input  wire logic        calibrating,
   input  wire logic        reference_missing,
   input  wire logic        primary_overrange,
   input  wire logic        secondary_overrange,
   input  wire logic        pll_locked,
   output logic [7:0]       operating_setup,
   output logic [7:0]       primary_channel_setup,
   output logic [7:0]       secondary_channel_setup,
   output logic [15:0]      excitation_port_setup,
   output logic [7:0]       averaging_word,
   output logic             result_length_sel,
   output logic             primary_bipolar,
   output logic             secondary_bipolar,
   output logic             soft_reset_pulse
);
   logic [2:0]             pins_s;
   logic                   sclk_s;
   logic                   din_s;
   logic                   cs_n_s;
   logic                   sclk_prev_q;
   logic                   rise;
   logic                   fall;
   dar_pkg::dar_state_t    state_q;
   logic [4:0]             bit_cnt_q;
   logic [15:0]            shift_in_q;
   logic [15:0]            rd_sh_q;
   logic [3:0]             addr_q;
   logic [5:0]             ones_q;
   logic                   ones_hit;
   logic [7:0]             status_q;
   logic [7:0]             cmd_byte;
   logic [15:0]            wr_word;
   logic                   last_bit;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [4:0] dar_len(input logic [3:0] a);
      dar_len = (a == dar_pkg::ADDR_EXCITE) ? dar_pkg::BITS_WORD
                                           : dar_pkg::BITS_BYTE;
   endfunction

   // Bytes sit in the upper half so the shift-out is MSB first
   function automatic logic [15:0] dar_read_val(input logic [3:0] a,
                                                input logic [7:0] st);
      case (a)
         dar_pkg::ADDR_STATUS:    dar_read_val = {st, 8'h00};
         dar_pkg::ADDR_OPERATING: dar_read_val = {operating_setup, 8'h00};
         dar_pkg::ADDR_PRIMARY:   dar_read_val =
                                     {primary_channel_setup, 8'h00};
         dar_pkg::ADDR_SECONDARY: dar_read_val =
                                     {secondary_channel_setup, 8'h00};
         dar_pkg::ADDR_DECIMATE:  dar_read_val = {averaging_word, 8'h00};
         dar_pkg::ADDR_EXCITE:    dar_read_val = excitation_port_setup;
         default:                 dar_read_val = 16'h0000;
      endcase
   endfunction

   // ****************************************************************
   // Pin capture
   // ****************************************************************
   // Clock and select enter inverted: a cleared stage reads as idle,
   // so leaving reset shows no false edge and no select
   dar_pin_sync #(
      .WIDTH      (3)
   ) u_sync (
      .sys_clk    (sys_clk),
      .reset      (reset),
      .pin_in     ({~sclk_pin, din_pin, ~cs_n_pin}),
      .pin_stable (pins_s)
   );

   assign sclk_s   = ~pins_s[2];
   assign din_s    = pins_s[1];
   assign cs_n_s   = ~pins_s[0];
   assign rise     = sclk_s & ~sclk_prev_q & ~cs_n_s;
   assign fall     = ~sclk_s & sclk_prev_q & ~cs_n_s;
   assign cmd_byte = {shift_in_q[6:0], din_s};
   assign wr_word  = {shift_in_q[14:0], din_s};
   assign last_bit = (bit_cnt_q == 5'(dar_len(addr_q) - 5'h01));
   assign ones_hit = rise & din_s &
                     (ones_q == 6'(dar_pkg::ONES_RESET - 6'h01));

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sclk_prev_q <= 1'b1;
      end else begin
         sclk_prev_q <= sclk_s;
      end
   end

   // ****************************************************************
   // Line reset by a run of ones
   // ****************************************************************
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ones_q           <= 6'h00;
         soft_reset_pulse <= 1'b0;
      end else begin
         soft_reset_pulse <= ones_hit;
         if (ones_hit) begin
            ones_q <= 6'h00;
         end else if (rise) begin
            ones_q <= din_s ? ones_q + 6'h01 : 6'h00;
         end
      end
   end

   // ****************************************************************
   // Status capture, live flags sampled every cycle
   // ****************************************************************
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         status_q <= dar_pkg::RST_STATUS;
      end else begin
         status_q <= {primary_result_ready, secondary_result_ready,
                      calibrating, reference_missing,
                      primary_overrange, secondary_overrange,
                      1'b0, pll_locked} & dar_pkg::MASK_STATUS;
      end
   end

   // ****************************************************************
   // Interface sequencer
   // ****************************************************************
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_q    <= dar_pkg::ST_CMD;
         bit_cnt_q  <= 5'h00;
         shift_in_q <= 16'h0000;
         addr_q     <= dar_pkg::ADDR_COMMAND;
      end else if (ones_hit) begin
         state_q    <= dar_pkg::ST_CMD;
         bit_cnt_q  <= 5'h00;
         addr_q     <= dar_pkg::ADDR_COMMAND;
      end else if (cs_n_s) begin
         // Deselect drops a partial frame but keeps the pending access
         bit_cnt_q  <= 5'h00;
      end else if (rise) begin
         shift_in_q <= wr_word;
         bit_cnt_q  <= bit_cnt_q + 5'h01;
         case (state_q)
            dar_pkg::ST_CMD: begin
               if (bit_cnt_q == 5'(dar_pkg::BITS_BYTE - 5'h01)) begin
                  bit_cnt_q <= 5'h00;
                  // A set write-enable bit means the byte is not a command
                  if (!cmd_byte[dar_pkg::CMD_WEN_BIT]) begin
                     addr_q  <= cmd_byte[3:0];
                     state_q <= cmd_byte[dar_pkg::CMD_READ_BIT]
                                ? dar_pkg::ST_READ
                                : dar_pkg::ST_WRITE;
                  end
               end
            end
            dar_pkg::ST_WRITE, dar_pkg::ST_READ: begin
               if (last_bit) begin
                  bit_cnt_q <= 5'h00;
                  state_q   <= dar_pkg::ST_CMD;
               end
            end
            default: begin
               state_q <= dar_pkg::ST_CMD;
            end
         endcase
      end
   end

   // ****************************************************************
   // Read data path, launched on falling serial clock
   // ****************************************************************
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rd_sh_q <= 16'h0000;
         dout    <= 1'b0;
         dout_oe <= 1'b0;
      end else begin
         dout_oe <= ~cs_n_s;
         if (rise && state_q == dar_pkg::ST_CMD &&
             bit_cnt_q == 5'(dar_pkg::BITS_BYTE - 5'h01) &&
             !cmd_byte[dar_pkg::CMD_WEN_BIT] &&
             cmd_byte[dar_pkg::CMD_READ_BIT]) begin
            rd_sh_q <= dar_read_val(cmd_byte[3:0], status_q);
         end else if (fall && state_q == dar_pkg::ST_READ) begin
            dout    <= rd_sh_q[15];
            rd_sh_q <= {rd_sh_q[14:0], 1'b0};
         end
      end
   end

   // ****************************************************************
   // Configuration registers
   // ****************************************************************
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         operating_setup         <= dar_pkg::RST_OPERATING;
         primary_channel_setup   <= dar_pkg::RST_PRIMARY;
         secondary_channel_setup <= dar_pkg::RST_SECONDARY;
         excitation_port_setup   <= dar_pkg::RST_EXCITE;
         averaging_word          <= dar_pkg::RST_DECIMATE;
      end else if (ones_hit) begin
         operating_setup         <= dar_pkg::RST_OPERATING;
         primary_channel_setup   <= dar_pkg::RST_PRIMARY;
         secondary_channel_setup <= dar_pkg::RST_SECONDARY;
         excitation_port_setup   <= dar_pkg::RST_EXCITE;
         averaging_word          <= dar_pkg::RST_DECIMATE;
      end else if (rise && state_q == dar_pkg::ST_WRITE && last_bit &&
                   !cs_n_s) begin
         case (addr_q)
            dar_pkg::ADDR_OPERATING:
               operating_setup <= wr_word[7:0] &
                                  dar_pkg::MASK_OPERATING;
            dar_pkg::ADDR_PRIMARY:
               primary_channel_setup <= wr_word[7:0];
            dar_pkg::ADDR_SECONDARY:
               secondary_channel_setup <= wr_word[7:0] &
                                          dar_pkg::MASK_SECONDARY;
            dar_pkg::ADDR_EXCITE:
               excitation_port_setup <= wr_word &
                                        dar_pkg::MASK_EXCITE;
            // No range clamp: out-of-range words are the host's fault
            dar_pkg::ADDR_DECIMATE:
               averaging_word <= wr_word[7:0];
            default: begin
            end
         endcase
      end
   end

   // ****************************************************************
   // Decoded controls, one rate word serves both converters
   // ****************************************************************
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         result_length_sel <= 1'b0;
         primary_bipolar   <= 1'b0;
         secondary_bipolar <= 1'b0;
      end else begin
         result_length_sel <=
            primary_channel_setup[dar_pkg::PRI_LEN_BIT];
         primary_bipolar   <=
            ~primary_channel_setup[dar_pkg::PRI_POL_BIT];
         secondary_bipolar <=
            ~secondary_channel_setup[dar_pkg::SEC_POL_BIT];
      end
   end
endmodule

/* File: verilog/dar_pkg.sv */
package dar_pkg;

   // ****************************************************************
   // Register addresses carried in the command byte
   // ****************************************************************
   localparam logic [3:0] ADDR_COMMAND   = 4'h0;
   localparam logic [3:0] ADDR_STATUS    = 4'h0;
   localparam logic [3:0] ADDR_OPERATING = 4'h1;
   localparam logic [3:0] ADDR_PRIMARY   = 4'h2;
   localparam logic [3:0] ADDR_SECONDARY = 4'h3;
   localparam logic [3:0] ADDR_DECIMATE  = 4'h4;
   localparam logic [3:0] ADDR_EXCITE    = 4'h7;

   // ****************************************************************
   // Command byte layout
   // ****************************************************************
   localparam int CMD_WEN_BIT  = 7;
   localparam int CMD_READ_BIT = 6;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int OPS_BUF_BIT    = 6;
   localparam int OPS_CHCFG_BIT  = 4;
   localparam int OPS_OSC_STOP_IN_POWERDOWN_BIT  = 3;
   localparam int PRI_LEN_BIT    = 6;
   localparam int PRI_POL_BIT    = 3;
   localparam int SEC_POL_BIT    = 3;

   // ****************************************************************
   // Writable bit masks, fixed zeros read back as zero
   // ****************************************************************
   localparam logic [7:0]  MASK_OPERATING = 8'h5F;
   localparam logic [7:0]  MASK_PRIMARY   = 8'hFF;
   localparam logic [7:0]  MASK_SECONDARY = 8'hF9;
   localparam logic [15:0] MASK_EXCITE    = 16'hDFFF;
   localparam logic [7:0]  MASK_STATUS    = 8'hFD;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [7:0]  RST_STATUS    = 8'h00;
   localparam logic [7:0]  RST_OPERATING = 8'h00;
   localparam logic [7:0]  RST_PRIMARY   = 8'h07;
   localparam logic [7:0]  RST_SECONDARY = 8'h01;
   localparam logic [15:0] RST_EXCITE    = 16'h0000;
   localparam logic [7:0]  RST_DECIMATE  = 8'h45;

   // ****************************************************************
   // Serial framing counts
   // ****************************************************************
   localparam logic [4:0] BITS_BYTE   = 5'h08;
   localparam logic [4:0] BITS_WORD   = 5'h10;
   localparam logic [5:0] ONES_RESET  = 6'h20;

   typedef enum logic [1:0] {
      ST_CMD,
      ST_WRITE,
      ST_READ
   } dar_state_t;

endpackage

/* File: verilog/dar_pin_sync.sv */
`timescale 1ns/1ps
module dar_pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             sys_clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] pin_stable
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   // ****************************************************************
   // Three stages, change taken when last two agree
   // ****************************************************************
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         s1_q       <= '0;
         s2_q       <= '0;
         s3_q       <= '0;
         pin_stable <= '0;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < WIDTH; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               pin_stable[i] <= s3_q[i];
            end
         end
      end
   end
endmodule

/* File: test/dar_regbank_props.sv */
`timescale 1ns/1ps
module dar_regbank_props (
   input wire logic        sys_clk,
   input wire logic        reset,
   input wire logic        cs_n_pin,
   input wire logic        dout_oe,
   input wire logic [7:0]  operating_setup,
   input wire logic [7:0]  primary_channel_setup,
   input wire logic [7:0]  secondary_channel_setup,
   input wire logic [15:0] excitation_port_setup,
   input wire logic [7:0]  averaging_word,
   input wire logic        result_length_sel,
   input wire logic        primary_bipolar,
   input wire logic        secondary_bipolar,
   input wire logic        soft_reset_pulse
);
   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   // Long enough for the pin synchroniser to settle
   sequence cs_idle;
      cs_n_pin [*8];
   endsequence
   sequence cs_busy;
      !cs_n_pin [*6];
   endsequence
   AST_LEN_FOLLOWS: assert property (
      !$past(reset) |-> result_length_sel == $past(primary_channel_setup[6]))
      else $error("length select does not follow setup");
   AST_PRI_POLARITY: assert property (
      !$past(reset) |-> primary_bipolar == !$past(primary_channel_setup[3]))
      else $error("primary polarity wrong");
   AST_SEC_POLARITY: assert property (
      !$past(reset) |->
      secondary_bipolar == !$past(secondary_channel_setup[3]))
      else $error("secondary polarity wrong");
   AST_OPS_FIXED_ZERO: assert property (
      (operating_setup & 8'hA0) == 8'h00)
      else $error("operating fixed bits set");
   AST_SEC_FIXED_ZERO: assert property (
      secondary_channel_setup[2:1] == 2'h0)
      else $error("secondary fixed bits set");
   AST_EXC_FIXED_ZERO: assert property (
      !excitation_port_setup[13])
      else $error("excitation fixed bit set");
   AST_PULSE_SINGLE: assert property (
      soft_reset_pulse |=> !soft_reset_pulse)
      else $error("line reset pulse too long");
   AST_PULSE_DEFAULTS: assert property (
      soft_reset_pulse |-> ##[0:2] (primary_channel_setup == 8'h07 &&
      averaging_word == 8'h45 && operating_setup == 8'h00))
      else $error("line reset left registers set");
   AST_OE_IDLE: assert property (
      cs_idle |-> !dout_oe)
      else $error("output driven while deselected");
   AST_OE_BUSY: assert property (
      cs_busy |-> dout_oe)
      else $error("output not driven while selected");
   AST_HOLD_IDLE: assert property (
      cs_idle |-> $stable(primary_channel_setup) &&
      $stable(averaging_word) && $stable(excitation_port_setup))
      else $error("register changed while deselected");
endmodule
bind dar_regbank dar_regbank_props u_props (
   .sys_clk, .reset, .cs_n_pin, .dout_oe, .operating_setup,
   .primary_channel_setup, .secondary_channel_setup,
   .excitation_port_setup, .averaging_word, .result_length_sel,
   .primary_bipolar, .secondary_bipolar, .soft_reset_pulse);

/* File: test/dar_host_model.sv */
`timescale 1ns/1ps
module dar_host_model (
   input  wire logic sys_clk,
   input  wire logic dout,
   output logic      sclk_pin,
   output logic      din_pin,
   output logic      cs_n_pin
);
   // ****************************************************************
   // Serial host, clock idles high between frames
   // ****************************************************************
   localparam int HALF = 7;
   initial begin
      sclk_pin = 1'b1;
      din_pin  = 1'b0;
      cs_n_pin = 1'b1;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic shift(input int n, input logic [15:0] wv,
                        output logic [15:0] rv);
      rv = 16'h0000;
      for (int i = n - 1; i >= 0; i--) begin
         sclk_pin = 1'b0;
         din_pin  = wv[i];
         wait_clk(HALF);
         rv[i]    = dout;
         sclk_pin = 1'b1;
         wait_clk(HALF);
      end
   endtask
   task automatic access(input logic [7:0] cmd, input int n,
                         input logic [15:0] wv, output logic [15:0] rv);
      logic [15:0] junk;
      cs_n_pin = 1'b0;
      wait_clk(HALF);
      shift(8, {8'h00, cmd}, junk);
      shift(n, wv, rv);
      wait_clk(HALF);
      cs_n_pin = 1'b1;
      // Released line must not look like a held level
      din_pin  = ~din_pin;
      // Gap long enough for the device to see a settled deselect
      wait_clk(2 * HALF);
   endtask
endmodule

/* File: test/dar_regbank_bench.sv */
`timescale 1ns/1ps
module dar_regbank_bench;
   logic        sys_clk = 1'b0;
   logic        reset = 1'b1;
   logic        sclk_pin, din_pin, cs_n_pin, dout, dout_oe;
   logic [7:0]  status_drive = 8'h00;
   logic [7:0]  op_q, pri_q, sec_q, avg_q;
   logic [15:0] exc_q, rv;
   logic        len_q, pbip_q, sbip_q, pulse_q;
   int          failures = 0;
   int          samples_checked = 0;
   int          pulses = 0;
   logic [3:0]  addr_tab [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7};
   logic [15:0] rst_tab [5] = '{16'h0000, 16'h0007, 16'h0001, 16'h0045,
                                16'h0000};
   logic [15:0] all_tab [5] = '{16'h005F, 16'h00FF, 16'h00F9, 16'h00FF,
                                16'hDFFF};
   // ****************************************************************
   // Device and host
   // ****************************************************************
   dar_regbank uut (
      .sys_clk, .reset, .sclk_pin, .din_pin, .cs_n_pin, .dout, .dout_oe,
      .primary_result_ready(status_drive[7]),
      .secondary_result_ready(status_drive[6]),
      .calibrating(status_drive[5]), .reference_missing(status_drive[4]),
      .primary_overrange(status_drive[3]),
      .secondary_overrange(status_drive[2]), .pll_locked(status_drive[0]),
      .operating_setup(op_q), .primary_channel_setup(pri_q),
      .secondary_channel_setup(sec_q), .excitation_port_setup(exc_q),
      .averaging_word(avg_q), .result_length_sel(len_q),
      .primary_bipolar(pbip_q), .secondary_bipolar(sbip_q),
      .soft_reset_pulse(pulse_q));
   dar_host_model host (.sys_clk, .dout, .sclk_pin, .din_pin, .cs_n_pin);
   initial begin
      forever #50 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (pulse_q === 1'b1) pulses++;
   end
   task automatic end_of_test();
      $display("failures %0d samples_checked %0d", failures,
               samples_checked);
      if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         $display("BAD %s exp %h seen %h", what, exp, seen);
         failures++;
      end
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      logic [15:0] v;
      host.access({4'h4, a}, (a == 4'h7) ? 16 : 8, 16'h0000, v);
      check($sformatf("reg %h", a), v, exp);
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      logic [15:0] v;
      host.access({4'h0, a}, (a == 4'h7) ? 16 : 8, d, v);
   endtask
   task automatic ports(input logic [15:0] lp, input logic [15:0] dec);
      check("pri", {8'h00, pri_q}, lp);
      check("decode", {13'h0000, len_q, pbip_q, sbip_q}, dec);
   endtask
   // Run is near 8k cycles, limit leaves wide margin
   initial begin
      #5000000;
      failures++;
      end_of_test();
   end
   initial begin
      repeat (16) @(posedge sys_clk);
      #1;
      reset = 1'b0;
      host.wait_clk(5);
      ports(16'h0007, 16'h0003);
      check("oe", {15'h0000, dout_oe}, 16'h0000);
      for (int i = 0; i < 5; i++) rd(addr_tab[i], rst_tab[i]);
      status_drive = 8'hFF;
      rd(4'h0, 16'h00FD);
      status_drive = 8'h5A;
      rd(4'h0, 16'h0058);
      for (int i = 0; i < 5; i++) wr(addr_tab[i], 16'hFFFF);
      for (int i = 0; i < 5; i++) rd(addr_tab[i], all_tab[i]);
      ports(16'h00FF, 16'h0004);
      check("exc", exc_q, 16'hDFFF);
      check("op", {8'h00, op_q}, 16'h005F);
      check("sec", {8'h00, sec_q}, 16'h00F9);
      host.access(8'h82, 0, 16'h0000, rv);
      rd(4'h2, 16'h00FF);
      wr(4'h5, 16'h00AA);
      rd(4'h5, 16'h0000);
      wr(4'h4, 16'h000D);
      check("avg", {8'h00, avg_q}, 16'h000D);
      host.access(8'hFF, 16, 16'hFFFF, rv);
      host.access(8'hFF, 16, 16'hFFFF, rv);
      check("pulses", pulses[15:0], 16'h0001);
      for (int i = 0; i < 5; i++) rd(addr_tab[i], rst_tab[i]);
      end_of_test();
   end
endmodule
